// ### verif/ims_master_seq_test.sv
`timescale 1ns/10ps
`include "ims_regs.svh"
module ims_master_seq_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic e;
  logic scl_oe_b;
  logic sda_oe_b;
  logic scl_o;
  logic sda_o;
  logic scl_rel;
  logic sda_rel;
  logic tb_sda = 1'b1;
  logic ack = 1'b1;
  logic tx = 1'b0;
  logic stretch = 1'b0;
  logic [7:0] rd = 8'h00;
  logic [7:0] got;
  logic [31:0] r;
  wire logic scl_w = (scl_oe_b | scl_o) & scl_rel;
  wire logic sda_w = (sda_oe_b | sda_o) & sda_rel & tb_sda;
  int n_errors = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  ims_master_seq dut (.CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_B_O(scl_oe_b), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE_B_O(sda_oe_b));
  ims_slave_model slave (.clk_i(clk), .rst_b_i(rst_b), .scl_i(scl_w), .sda_i(sda_w), .ack_i(ack),
    .tx_i(tx), .stretch_i(stretch), .rd_i(rd), .scl_rel_o(scl_rel), .sda_rel_o(sda_rel), .got_o(got));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic give_up();
    n_errors++;
    $display("mismatch wait expected done seen timeout");
    final_report();
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] v);
    total_checks++;
    if (v !== x)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, v);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      give_up();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `IMS_OFF_STAT, 32'h0);
      n++;
    end
    while (r[b] !== 1'b1 && n < 500);
    if (r[b] !== 1'b1)
      give_up();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(1'b0, `IMS_OFF_BAUD, 32'h0);
    chk("baud reset", {24'h0, `IMS_BAUD_RST}, r);
    apb(1'b0, `IMS_OFF_STAT, 32'h0);
    chk("status reset", 32'h0, r);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    apb(1'b1, `IMS_OFF_BAUD, 32'h10b);
    apb(1'b0, `IMS_OFF_BAUD, 32'h0);
    chk("baud low byte", 32'h0b, r);
    $display("test regs done");
  endtask
  task automatic t_start();
    int n;
    apb(1'b1, `IMS_OFF_CTRL, 32'h1);
    apb(1'b1, `IMS_OFF_CTRL, 32'h2);
    n = 0;
    while (sda_w !== 1'b0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (sda_w !== 1'b0)
      give_up();
    chk("start delay", 32'h1, {31'h0, n >= 9 && n <= 12});
    chk("scl at start", 32'h1, {31'h0, scl_w});
    apb(1'b0, `IMS_OFF_STAT, 32'h0);
    chk("seen, no event", 32'h20, r & 32'h28);
    wait_bit(`IMS_STAT_EVT);
    apb(1'b0, `IMS_OFF_CTRL, 32'h0);
    chk("requests clear", 32'h0, r & 32'h1f);
    chk("data kept low", 32'h0, {31'h0, sda_w});
    apb(1'b1, `IMS_OFF_STAT, 32'h3e);
    $display("test start done");
  endtask
  task automatic t_tx(input logic [7:0] b, input logic a);
    ack <= a;
    apb(1'b1, `IMS_OFF_BUF, {24'h0, b});
    apb(1'b1, `IMS_OFF_BUF, 32'hff);
    apb(1'b1, `IMS_OFF_CTRL, 32'h8);
    apb(1'b0, `IMS_OFF_STAT, 32'h0);
    chk("buf full", 32'h1, {31'h0, r[`IMS_STAT_BF]});
    chk("write_collision", 32'h1, {31'h0, r[`IMS_STAT_WRITE_COLLISION]});
    wait_bit(`IMS_STAT_EVT);
    chk("bf clear", 32'h0, {31'h0, r[`IMS_STAT_BF]});
    chk("byte", {24'h0, b}, {24'h0, got});
    chk("clock held", 32'h0, {31'h0, scl_w});
    apb(1'b0, `IMS_OFF_CTRL, 32'h0);
    chk("ack status", {31'h0, ~a}, {31'h0, r[`IMS_CTRL_ACK_STATUS]});
    chk("recv ignored", 32'h0, {31'h0, r[`IMS_CTRL_RECV]});
    apb(1'b1, `IMS_OFF_STAT, 32'h3e);
    $display("test tx %h done", b);
  endtask
  task automatic t_rx();
    tx <= 1'b1;
    rd <= 8'h3c;
    apb(1'b1, `IMS_OFF_CTRL, 32'h8);
    wait_bit(`IMS_STAT_EVT);
    chk("rx full", 32'h1, {31'h0, r[`IMS_STAT_BF]});
    apb(1'b0, `IMS_OFF_CTRL, 32'h0);
    chk("rx request", 32'h0, {31'h0, r[`IMS_CTRL_RECV]});
    apb(1'b0, `IMS_OFF_BUF, 32'h0);
    chk("rx byte", 32'h3c, r);
    apb(1'b0, `IMS_OFF_STAT, 32'h0);
    chk("read clears", 32'h0, {31'h0, r[`IMS_STAT_BF]});
    apb(1'b1, `IMS_OFF_STAT, 32'h3e);
    apb(1'b1, `IMS_OFF_CTRL, 32'h10);
    wait_bit(`IMS_STAT_EVT);
    rd <= 8'hc3;
    repeat (2)
    begin
      apb(1'b1, `IMS_OFF_STAT, 32'h08);
      apb(1'b1, `IMS_OFF_CTRL, 32'h8);
      wait_bit(`IMS_STAT_EVT);
    end
    apb(1'b0, `IMS_OFF_STAT, 32'h0);
    chk("overflow", 32'h4, r & 32'h4);
    apb(1'b0, `IMS_OFF_BUF, 32'h0);
    apb(1'b1, `IMS_OFF_STAT, 32'h3e);
    $display("test rx done");
  endtask
  task automatic t_restart();
    tx <= 1'b0;
    ack <= 1'b0;
    apb(1'b1, `IMS_OFF_CTRL, 32'h2);
    wait_bit(`IMS_STAT_EVT);
    chk("restart seen", 32'h1, {31'h0, r[`IMS_STAT_SSEEN]});
    chk("restart lines", 32'h0, {30'h0, scl_w, sda_w});
    apb(1'b0, `IMS_OFF_CTRL, 32'h0);
    chk("restart clear", 32'h0, r & 32'h1f);
    apb(1'b1, `IMS_OFF_STAT, 32'h3e);
    apb(1'b1, `IMS_OFF_CTRL, 32'h4);
    wait_bit(`IMS_STAT_EVT);
    chk("stop lines", 32'h3, {30'h0, scl_w, sda_w});
    apb(1'b0, `IMS_OFF_CTRL, 32'h0);
    chk("stop clear", 32'h0, r & 32'h1f);
    $display("test restart done");
  endtask
  task automatic t_coll();
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    tb_sda <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b1, `IMS_OFF_CTRL, 32'h1);
    wait_bit(`IMS_STAT_BCOL);
    apb(1'b0, `IMS_OFF_CTRL, 32'h0);
    chk("abort clears", 32'h0, r & 32'h1f);
    chk("lines freed", 32'h3, {30'h0, scl_oe_b, sda_oe_b});
    tb_sda <= 1'b1;
    $display("test collision done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_start();
    t_tx(8'ha6, 1'b1);
    t_tx(8'h5c, 1'b0);
    stretch <= 1'b1;
    t_tx(8'h81, 1'b1);
    stretch <= 1'b0;
    t_tx(8'ha7, 1'b1);
    t_rx();
    t_restart();
    t_coll();
    final_report();
  end
endmodule

// ### verif/ims_slave_model.sv
`timescale 1ns/10ps
module ims_slave_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // wire levels and behaviour
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_i,
  input wire logic tx_i,
  input wire logic stretch_i,
  input wire logic [7:0] rd_i,
  // line releases and captured byte
  output logic scl_rel_o,
  output logic sda_rel_o,
  output logic [7:0] got_o
);
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt;
  logic [3:0] idx;
  logic [4:0] hold;
  always_ff @(posedge clk_i)
  begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (!rst_b_i || (scl_i && scl_q && sda_q && !sda_i))
    begin
      cnt <= 4'h0;
      idx <= 4'h0;
      hold <= 5'h00;
    end
    else
    begin
      if (hold != 5'h00)
        hold <= hold - 5'h01;
      if (scl_i && !scl_q)
      begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt < 4'h8)
          got_o <= {got_o[6:0], sda_i};
      end
      // data only moves while the clock is low
      if (!scl_i && scl_q)
      begin
        idx <= cnt;
        if (stretch_i)
          hold <= 5'h14;
      end
    end
  end
  assign scl_rel_o = (hold == 5'h00);
  assign sda_rel_o = tx_i ? !(idx < 4'h8 && !rd_i[3'h7 - idx[2:0]]) : !(idx == 4'h8 && ack_i);
endmodule

// ### verilog/ims_master_seq.sv
// Function
// RULE_01 - start with both lines high reloads baud counter and counts
// RULE_02 - at timeout with lines high pull data low, set start seen
// RULE_03 - one more baud period, then clear start request, stop, keep data low
// RULE_04 - a low line at start or early clock low flags collision, go idle
// RULE_05 - restart request taken only when sequencer idle, else ignored
// RULE_06 - restart: clock low, count, release data, then release clock, reload; here data is released together with clock low, before the count
// RULE_07 - both high one period, data low one period, clock low, clear request
// RULE_08 - start seen set at detection, event flag only at timeout
// RULE_09 - restart collision on data low at clock rise or early clock fall
// RULE_10 - buffer write sets buffer full and starts the byte
// RULE_11 - bit placed after clock falls; clock low one period, high one period
// RULE_12 - after eighth falling clock clear buffer full and release data
// RULE_13 - ninth clock captures acknowledge into ack status
// RULE_14 - after ninth clock raise event, hold clock low until next write
// RULE_15 - buffer write while busy sets write collision, buffer untouched
// RULE_16 - receive request ignored unless sequencer idle
// RULE_17 - receive toggles clock per rollover and shifts data in
// RULE_18 - eighth receive fall: clear request, load buffer, flags, hold clock
// RULE_19 - reading the buffer clears buffer full
// RULE_20 - byte completing while buffer full sets receive overflow
// RULE_21 - software picks ack value and requests the ack sequence
// RULE_22 - software orders start, address, data, then stop or restart
// RULE_23 - released clock pauses counter until sampled high, then reloads
// RULE_24 - baud period is one full countdown from the reload value
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "ims_regs.svh"
module ims_master_seq
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // two-wire bus, open drain
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_B_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_B_O
);
  ims_pkg::ims_state_t s;
  ims_pkg::ims_state_t n;
  ims_pkg::ims_apb_req_t req;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic mapped;
  logic setup;
  logic wr;
  logic rd;
  logic idle_ok;
  logic abort;

  assign req = '{sel: PSEL_I, en: PENABLE_I, wr: PWRITE_I, addr: PADDR_I, wdata: PWDATA_I};
  assign scl_s = s.scl_sync[1];
  assign sda_s = s.sda_sync[1];
  // ----------------------------------------
  // baud period ends when counter hits zero
  // ----------------------------------------
  // RULE_24 full countdown
  assign tick = (s.cnt == 8'h00) && !s.wait_hi && !s.wait_lo;
  assign mapped = (req.addr == `IMS_OFF_CTRL) || (req.addr == `IMS_OFF_STAT) ||
                  (req.addr == `IMS_OFF_BAUD) || (req.addr == `IMS_OFF_BUF);
  assign setup = req.sel && !req.en;
  assign wr = req.sel && req.en && req.wr && mapped;
  assign rd = req.sel && req.en && !req.wr && mapped;
  // RULE_05 idle only
  assign idle_ok = (s.fsm == ims_pkg::IMS_IDLE) && !s.req_start && !s.req_restart &&
                   !s.req_stop && !s.req_recv && !s.req_ack;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    n = s;
    abort = 1'b0;
    n.scl_sync = {s.scl_sync[0], SCL_I};
    n.sda_sync = {s.sda_sync[0], SDA_I};
    // RULE_23 pause while released
    if (s.wait_hi)
    begin
      n.cnt = s.baud;
      if (scl_s)
      begin
        n.wait_hi = 1'b0;
      end
    end
    else if (s.wait_lo)
    begin
      n.cnt = s.baud;
      if (!scl_s)
      begin
        n.wait_lo = 1'b0;
      end
    end
    else if (s.fsm == ims_pkg::IMS_IDLE || tick)
    begin
      n.cnt = s.baud;
    end
    else
    begin
      n.cnt = s.cnt - 8'h01;
    end

    // register reads are captured in setup, so the data leaves a flop
    if (setup)
    begin
      case (req.addr)
        `IMS_OFF_CTRL:
        begin
          n.rdata = '0;
          n.rdata[`IMS_CTRL_START] = s.req_start;
          n.rdata[`IMS_CTRL_RESTART] = s.req_restart;
          n.rdata[`IMS_CTRL_STOP] = s.req_stop;
          n.rdata[`IMS_CTRL_RECV] = s.req_recv;
          n.rdata[`IMS_CTRL_ACKSEQ] = s.req_ack;
          n.rdata[`IMS_CTRL_ACKVAL] = s.ack_value;
          n.rdata[`IMS_CTRL_ACK_STATUS] = s.ack_status;
        end
        `IMS_OFF_STAT:
        begin
          n.rdata = '0;
          n.rdata[`IMS_STAT_BF] = s.bf;
          n.rdata[`IMS_STAT_WRITE_COLLISION] = s.write_collision;
          n.rdata[`IMS_STAT_OVF] = s.ovf;
          n.rdata[`IMS_STAT_EVT] = s.evt;
          n.rdata[`IMS_STAT_BCOL] = s.bcol;
          n.rdata[`IMS_STAT_SSEEN] = s.sseen;
          n.rdata[`IMS_STAT_BUSY] = !idle_ok;
        end
        `IMS_OFF_BAUD: n.rdata = {24'h000000, s.baud};
        `IMS_OFF_BUF: n.rdata = {24'h000000, s.tbuf};
        default: n.rdata = '0;
      endcase
    end

    // ----------------------------------------
    // register writes; status clears come first so hardware sets win
    // ----------------------------------------
    if (wr && req.addr == `IMS_OFF_CTRL)
    begin
      n.ack_value = req.wdata[`IMS_CTRL_ACKVAL];
      // RULE_05 restart ignored when busy
      // RULE_16 receive ignored when busy
      if (idle_ok)
      begin
        n.req_start = req.wdata[`IMS_CTRL_START];
        n.req_restart = req.wdata[`IMS_CTRL_RESTART];
        n.req_stop = req.wdata[`IMS_CTRL_STOP];
        n.req_recv = req.wdata[`IMS_CTRL_RECV];
        n.req_ack = req.wdata[`IMS_CTRL_ACKSEQ];
      end
    end
    if (wr && req.addr == `IMS_OFF_STAT)
    begin
      n.write_collision = s.write_collision && !req.wdata[`IMS_STAT_WRITE_COLLISION];
      n.ovf = s.ovf && !req.wdata[`IMS_STAT_OVF];
      n.evt = s.evt && !req.wdata[`IMS_STAT_EVT];
      n.bcol = s.bcol && !req.wdata[`IMS_STAT_BCOL];
      n.sseen = s.sseen && !req.wdata[`IMS_STAT_SSEEN];
    end
    if (wr && req.addr == `IMS_OFF_BAUD)
    begin
      n.baud = req.wdata[7:0];
    end
    if (wr && req.addr == `IMS_OFF_BUF)
    begin
      // RULE_10 load and go
      if (idle_ok)
      begin
        n.tbuf = req.wdata[7:0];
        n.shift = req.wdata[7:0];
        n.bf = 1'b1;
        n.fsm = ims_pkg::IMS_TX_LO;
        n.bitcnt = 4'h0;
        n.scl_low = 1'b1;
        n.sda_low = !req.wdata[7];
        n.cnt = s.baud;
      end
      // RULE_15 refused write
      else
      begin
        n.write_collision = 1'b1;
      end
    end
    // RULE_19 read clears full
    if (rd && req.addr == `IMS_OFF_BUF)
    begin
      n.bf = 1'b0;
    end

    // ----------------------------------------
    // bus sequencer
    // ----------------------------------------
    case (s.fsm)
      ims_pkg::IMS_IDLE:
      begin
        if (s.req_start)
        begin
          // RULE_01 reload and count
          if (sda_s && scl_s)
          begin
            n.fsm = ims_pkg::IMS_ST_A;
            n.scl_low = 1'b0;
            n.sda_low = 1'b0;
          end
          // RULE_04 line already low
          else
          begin
            abort = 1'b1;
          end
        end
        // RULE_06 clock low, data released
        else if (s.req_restart)
        begin
          n.fsm = ims_pkg::IMS_RS_A;
          n.scl_low = 1'b1;
          n.sda_low = 1'b0;
          n.wait_lo = 1'b1;
        end
        else if (s.req_stop)
        begin
          n.fsm = ims_pkg::IMS_SP_LO;
          n.scl_low = 1'b1;
          n.sda_low = 1'b1;
        end
        else if (s.req_recv)
        begin
          n.fsm = ims_pkg::IMS_RX_LO;
          n.scl_low = 1'b1;
          n.sda_low = 1'b0;
          n.bitcnt = 4'h0;
        end
        else if (s.req_ack)
        begin
          n.fsm = ims_pkg::IMS_ACK_LO;
          n.scl_low = 1'b1;
          n.sda_low = !s.ack_value;
        end
      end
      ims_pkg::IMS_ST_A:
      begin
        // RULE_04 clock low early
        if (!scl_s)
        begin
          abort = 1'b1;
        end
        // RULE_02 drive start
        else if (tick)
        begin
          if (sda_s)
          begin
            n.sda_low = 1'b1;
            n.sseen = 1'b1;
            n.fsm = ims_pkg::IMS_ST_B;
          end
          else
          begin
            abort = 1'b1;
          end
        end
      end
      ims_pkg::IMS_ST_B:
      begin
        // RULE_03 finish start
        // RULE_08 event at timeout
        if (tick)
        begin
          n.req_start = 1'b0;
          n.evt = 1'b1;
          n.fsm = ims_pkg::IMS_IDLE;
        end
      end
      ims_pkg::IMS_RS_A:
      begin
        // RULE_06 release clock
        if (tick)
        begin
          if (sda_s)
          begin
            n.scl_low = 1'b0;
            n.wait_hi = 1'b1;
            n.fsm = ims_pkg::IMS_RS_B;
          end
          else
          begin
            abort = 1'b1;
          end
        end
      end
      ims_pkg::IMS_RS_B:
      begin
        // RULE_09 data low at rise, or clock dropped
        if ((s.wait_hi && scl_s && !sda_s) || (!s.wait_hi && !scl_s))
        begin
          abort = 1'b1;
        end
        // RULE_07 start under high clock
        // RULE_08 seen at detection
        else if (tick)
        begin
          n.sda_low = 1'b1;
          n.sseen = 1'b1;
          n.fsm = ims_pkg::IMS_RS_C;
        end
      end
      ims_pkg::IMS_RS_C:
      begin
        // RULE_09 clock dropped before end
        if (!scl_s)
        begin
          abort = 1'b1;
        end
        // RULE_07 clock low, clear request
        else if (tick)
        begin
          n.scl_low = 1'b1;
          n.req_restart = 1'b0;
          n.evt = 1'b1;
          n.fsm = ims_pkg::IMS_IDLE;
        end
      end
      ims_pkg::IMS_TX_LO, ims_pkg::IMS_RX_LO, ims_pkg::IMS_ACK_LO, ims_pkg::IMS_SP_LO:
      begin
        // RULE_11 low phase, then release
        // RULE_17 toggle on rollover
        if (tick)
        begin
          n.scl_low = 1'b0;
          n.wait_hi = 1'b1;
          n.fsm = ims_pkg::ims_fsm_t'({s.fsm[13:0], 1'b0});
        end
      end
      ims_pkg::IMS_TX_HI:
      begin
        if (s.wait_hi && scl_s)
        begin
          // RULE_13 capture acknowledge
          if (s.bitcnt == `IMS_ACK_BIT)
          begin
            n.ack_status = sda_s;
          end
          // a released one read back as zero means lost arbitration
          else if (!s.sda_low && !sda_s)
          begin
            abort = 1'b1;
          end
        end
        else if (tick)
        begin
          n.scl_low = 1'b1;
          n.bitcnt = s.bitcnt + 4'h1;
          n.fsm = ims_pkg::IMS_TX_LO;
          // RULE_14 event and hold clock low
          if (s.bitcnt == `IMS_ACK_BIT)
          begin
            n.evt = 1'b1;
            n.fsm = ims_pkg::IMS_IDLE;
          end
          // RULE_12 release for acknowledge
          else if (s.bitcnt == `IMS_LAST_BIT)
          begin
            n.bf = 1'b0;
            n.sda_low = 1'b0;
          end
          // RULE_11 next bit after fall
          else
          begin
            n.shift = {s.shift[6:0], 1'b0};
            n.sda_low = !s.shift[6];
          end
        end
      end
      ims_pkg::IMS_RX_HI:
      begin
        // RULE_17 shift sampled data
        if (s.wait_hi && scl_s)
        begin
          n.shift = {s.shift[6:0], sda_s};
        end
        else if (tick)
        begin
          n.scl_low = 1'b1;
          n.bitcnt = s.bitcnt + 4'h1;
          n.fsm = ims_pkg::IMS_RX_LO;
          // RULE_18 byte complete
          if (s.bitcnt == `IMS_LAST_BIT)
          begin
            n.req_recv = 1'b0;
            n.tbuf = s.shift;
            n.bf = 1'b1;
            n.evt = 1'b1;
            n.fsm = ims_pkg::IMS_IDLE;
            // RULE_20 previous byte unread
            if (s.bf)
            begin
              n.ovf = 1'b1;
            end
          end
        end
      end
      ims_pkg::IMS_ACK_HI:
      begin
        if (tick)
        begin
          n.scl_low = 1'b1;
          n.req_ack = 1'b0;
          n.evt = 1'b1;
          n.fsm = ims_pkg::IMS_IDLE;
        end
      end
      ims_pkg::IMS_SP_HI:
      begin
        if (tick)
        begin
          n.sda_low = 1'b0;
          n.fsm = ims_pkg::IMS_SP_END;
        end
      end
      ims_pkg::IMS_SP_END:
      begin
        if (tick)
        begin
          n.req_stop = 1'b0;
          n.evt = 1'b1;
          n.fsm = ims_pkg::IMS_IDLE;
        end
      end
      default:
      begin
        n.fsm = ims_pkg::IMS_IDLE;
      end
    endcase

    // collision: lines released, every request dropped, shifting halted
    if (abort)
    begin
      n.bcol = 1'b1;
      n.fsm = ims_pkg::IMS_IDLE;
      n.scl_low = 1'b0;
      n.sda_low = 1'b0;
      n.wait_hi = 1'b0;
      n.wait_lo = 1'b0;
      n.bf = 1'b0;
      n.req_start = 1'b0;
      n.req_restart = 1'b0;
      n.req_stop = 1'b0;
      n.req_recv = 1'b0;
      n.req_ack = 1'b0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_B_I)
    begin
      s <= '0;
      s.fsm <= ims_pkg::IMS_IDLE;
      s.baud <= `IMS_BAUD_RST;
      s.cnt <= `IMS_BAUD_RST;
      s.scl_sync <= 2'h3;
      s.sda_sync <= 2'h3;
    end
    else
    begin
      s <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign PRDATA_O = s.rdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = req.sel && req.en && !mapped;
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_B_O = !s.scl_low;
  assign SDA_OE_B_O = !s.sda_low;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_start_reload: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_01
    (s.fsm == ims_pkg::IMS_IDLE && s.req_start && sda_s && scl_s)
    |=> (s.fsm == ims_pkg::IMS_ST_A && s.cnt == s.baud))
    else $error("start did not reload baud counter");
  a_start_drive: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_02
    (s.fsm == ims_pkg::IMS_ST_A && tick && sda_s && scl_s)
    |=> (!SDA_OE_B_O && SCL_OE_B_O && s.sseen && !s.evt))
    else $error("start condition not driven");
  a_start_done: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_03
    (s.fsm == ims_pkg::IMS_ST_B && tick)
    |=> (!s.req_start && s.evt && !SDA_OE_B_O && s.fsm == ims_pkg::IMS_IDLE)[*2])
    else $error("start did not complete");
  a_start_coll: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_04
    (s.fsm == ims_pkg::IMS_IDLE && s.req_start && !(sda_s && scl_s))
    |=> (s.bcol && !s.req_start && SDA_OE_B_O && SCL_OE_B_O))
    else $error("start collision missed");
  a_tx_load: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_10
    (wr && req.addr == `IMS_OFF_BUF && idle_ok)
    |=> (s.bf && s.fsm == ims_pkg::IMS_TX_LO && s.tbuf == $past(req.wdata[7:0])))
    else $error("buffer write did not start byte");
  a_ack_capture: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_13
    (s.fsm == ims_pkg::IMS_TX_HI && s.bitcnt == `IMS_ACK_BIT && s.wait_hi && scl_s)
    |=> (s.ack_status == $past(sda_s)))
    else $error("acknowledge not captured");
  a_tx_end: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_14
    (s.fsm == ims_pkg::IMS_TX_HI && tick && s.bitcnt == `IMS_ACK_BIT)
    |=> (s.evt && !SCL_OE_B_O && s.fsm == ims_pkg::IMS_IDLE))
    else $error("byte end not flagged");
  a_write_collision_set: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_15
    (wr && req.addr == `IMS_OFF_BUF && !idle_ok)
    |=> (s.write_collision && $stable(s.tbuf)))
    else $error("refused write changed buffer");
  a_rx_done: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_18
    (s.fsm == ims_pkg::IMS_RX_HI && tick && s.bitcnt == `IMS_LAST_BIT)
    |=> (s.bf && s.evt && !s.req_recv && !SCL_OE_B_O && s.tbuf == $past(s.shift)))
    else $error("received byte not delivered");
  a_rx_ovf: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_20
    (s.fsm == ims_pkg::IMS_RX_HI && tick && s.bitcnt == `IMS_LAST_BIT && s.bf)
    |=> s.ovf)
    else $error("overflow not flagged");
  a_hi_pause: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RULE_23
    (s.wait_hi && !scl_s) |=> (s.cnt == s.baud && $stable(s.fsm)))
    else $error("counter ran while clock held low");
endmodule

// ### verilog/ims_pkg.sv
package ims_pkg;
  // ----------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------
  typedef enum logic [14:0] {
    IMS_IDLE    = 15'h0001,
    IMS_ST_A    = 15'h0002,
    IMS_ST_B    = 15'h0004,
    IMS_RS_A    = 15'h0008,
    IMS_RS_B    = 15'h0010,
    IMS_RS_C    = 15'h0020,
    IMS_TX_LO   = 15'h0040,
    IMS_TX_HI   = 15'h0080,
    IMS_RX_LO   = 15'h0100,
    IMS_RX_HI   = 15'h0200,
    IMS_ACK_LO  = 15'h0400,
    IMS_ACK_HI  = 15'h0800,
    IMS_SP_LO   = 15'h1000,
    IMS_SP_HI   = 15'h2000,
    IMS_SP_END  = 15'h4000
  } ims_fsm_t;

  // ----------------------------------------
  // apb request bundle
  // ----------------------------------------
  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ims_apb_req_t;

  // ----------------------------------------
  // whole module state
  // ----------------------------------------
  typedef struct packed {
    ims_fsm_t fsm;
    logic [7:0] cnt;
    logic [3:0] bitcnt;
    logic wait_hi;
    logic wait_lo;
    logic scl_low;
    logic sda_low;
    logic [7:0] shift;
    logic [7:0] tbuf;
    logic [7:0] baud;
    logic req_start;
    logic req_restart;
    logic req_stop;
    logic req_recv;
    logic req_ack;
    logic ack_value;
    logic ack_status;
    logic bf;
    logic write_collision;
    logic ovf;
    logic evt;
    logic bcol;
    logic sseen;
    logic [31:0] rdata;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
  } ims_state_t;
endpackage

// ### verilog/ims_regs.svh
`ifndef IMS_REGS_SVH
`define IMS_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define IMS_OFF_CTRL 8'h00
`define IMS_OFF_STAT 8'h04
`define IMS_OFF_BAUD 8'h08
`define IMS_OFF_BUF 8'h0c
// ----------------------------------------
// control_two fields
// ----------------------------------------
`define IMS_CTRL_START 0
`define IMS_CTRL_RESTART 1
`define IMS_CTRL_STOP 2
`define IMS_CTRL_RECV 3
`define IMS_CTRL_ACKSEQ 4
`define IMS_CTRL_ACKVAL 5
`define IMS_CTRL_ACK_STATUS 6
// ----------------------------------------
// serial_status fields
// ----------------------------------------
`define IMS_STAT_BF 0
`define IMS_STAT_WRITE_COLLISION 1
`define IMS_STAT_OVF 2
`define IMS_STAT_EVT 3
`define IMS_STAT_BCOL 4
`define IMS_STAT_SSEEN 5
`define IMS_STAT_BUSY 6
// ----------------------------------------
// reset values and bit counts
// ----------------------------------------
`define IMS_BAUD_RST 8'h09
`define IMS_LAST_BIT 4'h7
`define IMS_ACK_BIT 4'h8
`endif
